/* File: rtl/dsl_pkg.sv */
// shared constants and types for the dual converter serial load link
package dsl_pkg;

   // frame layout
   localparam int unsigned FRAME_BITS   = 24;
   localparam int unsigned CNT_W        = 5;
   localparam int unsigned DATA_W       = 16;
   localparam int unsigned RD_BIT       = 23;
   localparam int unsigned ADDR_LSB     = 16;
   localparam int unsigned ADDR_W       = 3;
   localparam logic [CNT_W-1:0] CNT_FULL = 5'h18;
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

   // register selects carried in the address field
   localparam logic [ADDR_W-1:0] REG_CHAN_A    = 3'h0;
   localparam logic [ADDR_W-1:0] REG_CHAN_B    = 3'h1;
   localparam logic [ADDR_W-1:0] REG_CHAN_BOTH = 3'h2;
   localparam logic [ADDR_W-1:0] REG_CTRL      = 3'h3;

   // control word bit positions and reset value
   localparam int unsigned CTRL_W           = 3;
   localparam int unsigned CTRL_CLR_MID_BIT = 0;
   localparam int unsigned CTRL_BIPOLAR_BIT = 1;
   localparam int unsigned CTRL_SDO_EN_BIT  = 2;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

   // codes, all held internally as straight binary
   localparam logic [DATA_W-1:0] CODE_ZERO  = 16'h0000;
   localparam logic [DATA_W-1:0] CODE_MID   = 16'h8000;
   localparam logic [DATA_W-1:0] CODE_RESET = 16'h0000;
   localparam logic [15:0]       MSB_FLIP   = 16'h8000;
   localparam logic [7:0]        RB_PAD     = 8'h00;

   // synchroniser depth for pins
   localparam int unsigned SYNC_STAGES = 3;

   // timing, host side
   localparam int unsigned CLK_NS          = 20;
   localparam int unsigned SCLK_MAX_MHZ    = 30;
   localparam int unsigned SYNC_HIGH_NS    = 200;
   localparam int unsigned LOAD_OUTPUTS_N_LOW_NS     = 20;
   localparam int unsigned SYNC_HIGH_CYC   = (SYNC_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned LOAD_OUTPUTS_N_LOW_CYC    = (LOAD_OUTPUTS_N_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned SCLK_MIN_HALF_NS = (1000 + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
   localparam int unsigned HALF_CYC        = 4;
   localparam logic [3:0]  HALF_LAST       = 4'(HALF_CYC - 1);
   localparam logic [3:0]  GAP_LAST        = 4'(SYNC_HIGH_CYC - 1);
   // a one-cycle low pulse would slip through the converter's pin filter unseen
   localparam logic [3:0]  LOAD_OUTPUTS_N_LAST       = 4'(LOAD_OUTPUTS_N_LOW_CYC + SYNC_STAGES);

   // host sequencer
   typedef enum logic [2:0]
   {
      DSL_IDLE  = 3'b001,
      DSL_FRAME = 3'b010,
      DSL_GAP   = 3'b100
   } dsl_host_st_t;

endpackage : dsl_pkg

/* File: rtl/dsl_if.sv */
// link wires between the host controller and the converter front end
`timescale 1ns/1ps
interface dsl_if;
   logic sclk;
   logic sync_n;
   logic serial_data_in;
   logic load_outputs_n;
   logic clear_outputs_n;
   logic serial_data_out;
   logic sdo_oe;
   logic sdo_line;

   // undriven output line is pulled high on the board
   assign sdo_line = sdo_oe ? serial_data_out : 1'b1;

   modport dev
   (
      input  sclk,
      input  sync_n,
      input  serial_data_in,
      input  load_outputs_n,
      input  clear_outputs_n,
      output serial_data_out,
      output sdo_oe
   );

   modport host
   (
      output sclk,
      output sync_n,
      output serial_data_in,
      output load_outputs_n,
      output clear_outputs_n,
      input  sdo_line
   );
endinterface : dsl_if

/* File: rtl/dsl_dev.sv */
// converter front end: serial shift register, channel registers, load and clear
// Function
// - shift one bit per sclk fall in frame
// - frame sync rise closes frame, latches word
// - host keeps sclk at or below 30 MHz
// - host holds data stable at sclk fall
// - load low: output updates at frame end
// - load high: input register only, output held
// - load fall moves both channels together
// - clear low forces zero or midscale code
// - bipolar: strap high offset, low twos
// - unipolar: always straight binary
// - serial out driven only in readback/chain
// - serial out changes on sclk rise
// - host samples serial out late in sclk low, as sclk rises
// - bipolar zero: 0x8000 binary, 0x0000 twos
`timescale 1ns/1ps
module dsl_dev
(
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   dsl_if.dev                            link,
   input  wire logic                     bipolar_coding_select,
   output logic [dsl_pkg::DATA_W-1:0]    dac_code_a,
   output logic [dsl_pkg::DATA_W-1:0]    dac_code_b,
   output logic                          bipolar_range
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   localparam int unsigned NIN = 4;
   localparam int unsigned I_SYNC = 3;
   localparam int unsigned I_LOAD = 2;
   localparam int unsigned I_CLR  = 1;
   localparam int unsigned I_CODE = 0;

   // link clock domain
   logic [dsl_pkg::FRAME_BITS-1:0] shift_q;
   logic [dsl_pkg::CNT_W-1:0]      cnt_q;
   logic                           ack_seen_q;
   logic                           sdo_q;
   logic                           first_bit;
   logic [dsl_pkg::FRAME_BITS-1:0] shift_d;

   // system clock domain
   logic [NIN-1:0]                 pin_raw;
   logic [NIN-1:0]                 s1_q;
   logic [NIN-1:0]                 s2_q;
   logic [NIN-1:0]                 s3_q;
   logic [NIN-1:0]                 filt_q;
   logic [NIN-1:0]                 filt_prev_q;
   logic                           ack_q;
   logic [dsl_pkg::CTRL_W-1:0]     ctrl_q;
   logic [dsl_pkg::DATA_W-1:0]     in_a_q;
   logic [dsl_pkg::DATA_W-1:0]     in_b_q;
   logic [dsl_pkg::DATA_W-1:0]     out_a_q;
   logic [dsl_pkg::DATA_W-1:0]     out_b_q;
   logic [dsl_pkg::FRAME_BITS-1:0] rb_word_q;
   logic                           rb_load_q;
   logic                           sdo_oe_q;

   logic                           frame_end;
   logic                           frame_ok;
   logic                           load_fall;
   logic                           clr_act;
   logic                           load_low;
   logic                           is_rd;
   logic [dsl_pkg::ADDR_W-1:0]     addr;
   logic [dsl_pkg::DATA_W-1:0]     data;
   logic [dsl_pkg::DATA_W-1:0]     conv;
   logic                           wr_a;
   logic                           wr_b;
   logic                           wr_ctrl;
   logic [dsl_pkg::DATA_W-1:0]     clr_code;
   logic [dsl_pkg::DATA_W-1:0]     rb_val;

   ////////////////////////////////////////////////////////////////////////////
   // code conversion to the internal straight binary form

   // twos complement only differs from offset binary by the msb
   function automatic logic [dsl_pkg::DATA_W-1:0] to_straight
   (
      input logic [dsl_pkg::DATA_W-1:0] code,
      input logic                       bipolar,
      input logic                       offset_sel
   );
      logic [dsl_pkg::DATA_W-1:0] r;
      r = code;
      if (bipolar && !offset_sel)
         r = code ^ dsl_pkg::MSB_FLIP;
      return r; // unipolar passes unchanged
   endfunction : to_straight

   ////////////////////////////////////////////////////////////////////////////
   // link clock domain: shift register and serial output

   // a new frame is recognised when the capture toggle moved since last bit
   assign first_bit = (ack_seen_q != ack_q) || (cnt_q == dsl_pkg::CNT_ZERO);

   // rb_word_q is quasi static: written only after a frame closes and held
   // for the whole next frame, so it is safe to read here without a crossing
   assign shift_d = (first_bit && rb_load_q)
                    ? {rb_word_q[dsl_pkg::FRAME_BITS-2:0], link.serial_data_in}
                    : {shift_q[dsl_pkg::FRAME_BITS-2:0], link.serial_data_in};

   // shift on falling sclk, only inside a frame
   always_ff @(negedge link.sclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shift_q    <= '0;
         cnt_q      <= dsl_pkg::CNT_ZERO;
         ack_seen_q <= 1'b0;
      end
      else if (!link.sync_n)
      begin
         shift_q    <= shift_d;
         ack_seen_q <= ack_q;
         if (ack_seen_q != ack_q)
            cnt_q <= 5'h01;
         else if (cnt_q != dsl_pkg::CNT_FULL)
            cnt_q <= cnt_q + 5'h01;
      end
   end

   // output bit moves on the rising edge so it is settled at the next fall
   always_ff @(posedge link.sclk or negedge rst_n)
   begin
      if (!rst_n)
         sdo_q <= 1'b0;
      else
         sdo_q <= shift_q[dsl_pkg::FRAME_BITS-1];
   end

   assign link.serial_data_out = sdo_q;
   assign link.sdo_oe          = sdo_oe_q;

   ////////////////////////////////////////////////////////////////////////////
   // system clock domain: pin synchronisers

   assign pin_raw = {link.sync_n, link.load_outputs_n, link.clear_outputs_n,
                     bipolar_coding_select};

   // three stages; a level counts once stages two and three agree
   generate
      for (genvar i = 0; i < NIN; i++)
      begin : g_sync
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               s1_q[i]        <= 1'b1;
               s2_q[i]        <= 1'b1;
               s3_q[i]        <= 1'b1;
               filt_q[i]      <= 1'b1;
               filt_prev_q[i] <= 1'b1;
            end
            else
            begin
               s1_q[i]        <= pin_raw[i];
               s2_q[i]        <= s1_q[i];
               s3_q[i]        <= s2_q[i];
               filt_prev_q[i] <= filt_q[i];
               if (s2_q[i] == s3_q[i])
                  filt_q[i] <= s3_q[i];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // frame decode

   // sclk is idle after the frame, so shift_q and cnt_q are stable here
   assign frame_end = filt_q[I_SYNC] && !filt_prev_q[I_SYNC];
   assign frame_ok  = frame_end && (cnt_q == dsl_pkg::CNT_FULL);
   assign load_fall = !filt_q[I_LOAD] && filt_prev_q[I_LOAD];
   assign load_low  = !filt_q[I_LOAD];
   assign clr_act   = !filt_q[I_CLR];
   assign is_rd     = shift_q[dsl_pkg::RD_BIT];
   assign addr      = shift_q[dsl_pkg::ADDR_LSB +: dsl_pkg::ADDR_W];
   assign data      = shift_q[dsl_pkg::DATA_W-1:0];
   assign conv      = to_straight(data, ctrl_q[dsl_pkg::CTRL_BIPOLAR_BIT],
                                  filt_q[I_CODE]);
   assign wr_a      = frame_ok && !is_rd &&
                      ((addr == dsl_pkg::REG_CHAN_A) || (addr == dsl_pkg::REG_CHAN_BOTH));
   assign wr_b      = frame_ok && !is_rd &&
                      ((addr == dsl_pkg::REG_CHAN_B) || (addr == dsl_pkg::REG_CHAN_BOTH));
   assign wr_ctrl   = frame_ok && !is_rd && (addr == dsl_pkg::REG_CTRL);
   assign clr_code  = ctrl_q[dsl_pkg::CTRL_CLR_MID_BIT] ? dsl_pkg::CODE_MID
                                                         : dsl_pkg::CODE_ZERO;

   // readback selection, unknown selects read as zero
   assign rb_val = (addr == dsl_pkg::REG_CHAN_A) ? in_a_q :
                   (addr == dsl_pkg::REG_CHAN_B) ? in_b_q :
                   (addr == dsl_pkg::REG_CTRL)   ? {13'h0000, ctrl_q} :
                                                   dsl_pkg::CODE_ZERO;

   ////////////////////////////////////////////////////////////////////////////
   // frame capture, control and readback

   // toggle tells the link side the word was taken; short frames are dropped
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_q     <= 1'b0;
         ctrl_q    <= dsl_pkg::CTRL_RESET;
         rb_word_q <= '0;
         rb_load_q <= 1'b0;
         sdo_oe_q  <= 1'b0;
      end
      else
      begin
         if (frame_end)
            ack_q <= ~ack_q;
         if (wr_ctrl)
            ctrl_q <= data[dsl_pkg::CTRL_W-1:0];
         if (frame_ok)
         begin
            rb_load_q <= is_rd;
            rb_word_q <= {dsl_pkg::RB_PAD, rb_val};
         end
         sdo_oe_q <= ctrl_q[dsl_pkg::CTRL_SDO_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input registers

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         in_a_q <= dsl_pkg::CODE_RESET;
         in_b_q <= dsl_pkg::CODE_RESET;
      end
      else
      begin
         if (wr_a)
            in_a_q <= conv;
         if (wr_b)
            in_b_q <= conv;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output registers: clear wins, then load fall, then direct update

   // clear is level held, so any load during it is overridden
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_a_q <= dsl_pkg::CODE_RESET;
         out_b_q <= dsl_pkg::CODE_RESET;
      end
      else if (clr_act)
      begin
         out_a_q <= clr_code;
         out_b_q <= clr_code;
      end
      else if (load_fall)
      begin
         out_a_q <= in_a_q;
         out_b_q <= in_b_q;
      end
      else if (load_low)
      begin
         if (wr_a)
            out_a_q <= conv;
         if (wr_b)
            out_b_q <= conv;
      end
   end

   assign dac_code_a    = out_a_q;
   assign dac_code_b    = out_b_q;
   assign bipolar_range = ctrl_q[dsl_pkg::CTRL_BIPOLAR_BIT];

endmodule : dsl_dev

/* File: rtl/dsl_host.sv */
// host controller end: frames words out, drives load and clear pins
`timescale 1ns/1ps
module dsl_host
(
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   dsl_if.host                              link,
   input  wire logic                        req_valid,
   input  wire logic [dsl_pkg::FRAME_BITS-1:0] req_word,
   output logic                             req_ready,
   output logic                             rsp_valid,
   output logic [dsl_pkg::FRAME_BITS-1:0]   rsp_word,
   input  wire logic                        hold_outputs,
   input  wire logic                        load_strobe,
   input  wire logic                        clear_req
);

   dsl_pkg::dsl_host_st_t          st_q;
   logic [3:0]                     div_q;
   logic [3:0]                     gap_q;
   logic [3:0]                     load_outputs_n_cnt_q;
   logic [dsl_pkg::CNT_W-1:0]      bit_q;
   logic [dsl_pkg::FRAME_BITS-1:0] sh_q;
   logic [dsl_pkg::FRAME_BITS-1:0] rx_q;
   logic [dsl_pkg::FRAME_BITS-1:0] rsp_q;
   logic                           sclk_q;
   logic                           sync_q;
   logic                           sdi_q;
   logic                           load_outputs_n_q;
   logic                           clr_q;
   logic                           ready_q;
   logic                           rsp_v_q;
   logic                           pend_q;
   logic [2:0]                     sdo_s_q;
   logic                           sdo_f_q;
   logic                           half_end;
   logic                           start;
   logic                           load_outputs_n_go;

   ////////////////////////////////////////////////////////////////////////////
   // serial output pin synchroniser, sampled late in the low half period

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sdo_s_q <= 3'h7;
         sdo_f_q <= 1'b1;
      end
      else
      begin
         sdo_s_q <= {sdo_s_q[1:0], link.sdo_line};
         if (sdo_s_q[1] == sdo_s_q[2])
            sdo_f_q <= sdo_s_q[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame sequencer; sclk is clk divided by twice HALF_CYC, idles high

   assign half_end = (div_q == dsl_pkg::HALF_LAST);
   assign start    = (st_q == dsl_pkg::DSL_IDLE) && req_valid && ready_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q    <= dsl_pkg::DSL_IDLE;
         div_q   <= 4'h0;
         gap_q   <= 4'h0;
         bit_q   <= dsl_pkg::CNT_ZERO;
         sh_q    <= '0;
         rx_q    <= '0;
         rsp_q   <= '0;
         sclk_q  <= 1'b1;
         sync_q  <= 1'b1;
         sdi_q   <= 1'b0;
         rsp_v_q <= 1'b0;
      end
      else
      begin
         rsp_v_q <= 1'b0;
         case (st_q)
            dsl_pkg::DSL_IDLE:
            begin
               if (start)
               begin
                  st_q   <= dsl_pkg::DSL_FRAME;
                  sync_q <= 1'b0;
                  sh_q   <= req_word;
                  sdi_q  <= req_word[dsl_pkg::FRAME_BITS-1];
                  div_q  <= 4'h0;
                  bit_q  <= dsl_pkg::CNT_ZERO;
               end
            end
            dsl_pkg::DSL_FRAME:
            begin
               div_q <= half_end ? 4'h0 : div_q + 4'h1;
               if (half_end && sclk_q)
               begin
                  if (bit_q == dsl_pkg::CNT_FULL)
                  begin
                     sync_q <= 1'b1;
                     gap_q  <= 4'h0;
                     st_q   <= dsl_pkg::DSL_GAP;
                  end
                  else
                     sclk_q <= 1'b0; // device samples sdi here
               end
               else if (half_end)
               begin
                  // bit sampled after the fall, before the next change
                  sclk_q <= 1'b1;
                  rx_q   <= {rx_q[dsl_pkg::FRAME_BITS-2:0], sdo_f_q};
                  sh_q   <= {sh_q[dsl_pkg::FRAME_BITS-2:0], 1'b0};
                  sdi_q  <= sh_q[dsl_pkg::FRAME_BITS-2];
                  bit_q  <= bit_q + 5'h01;
               end
            end
            dsl_pkg::DSL_GAP:
            begin
               gap_q <= gap_q + 4'h1;
               if (gap_q == dsl_pkg::GAP_LAST)
               begin
                  st_q    <= dsl_pkg::DSL_IDLE;
                  rsp_q   <= rx_q;
                  rsp_v_q <= 1'b1;
               end
            end
            default:
               st_q <= dsl_pkg::DSL_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // load pin: tied low unless holding, then pulsed low between frames

   assign load_outputs_n_go = pend_q && (st_q == dsl_pkg::DSL_IDLE) && (load_outputs_n_cnt_q == 4'h0);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pend_q     <= 1'b0;
         load_outputs_n_cnt_q <= 4'h0;
         load_outputs_n_q     <= 1'b1;
         clr_q      <= 1'b1;
         ready_q    <= 1'b0;
      end
      else
      begin
         clr_q <= ~clear_req;
         if (load_strobe && hold_outputs)
            pend_q <= 1'b1;
         else if (load_outputs_n_go)
            pend_q <= 1'b0;
         if (load_outputs_n_go)
            load_outputs_n_cnt_q <= dsl_pkg::LOAD_OUTPUTS_N_LAST;
         else if (load_outputs_n_cnt_q != 4'h0)
            load_outputs_n_cnt_q <= load_outputs_n_cnt_q - 4'h1;
         load_outputs_n_q  <= hold_outputs ? !(load_outputs_n_go || (load_outputs_n_cnt_q > 4'h1)) : 1'b0;
         ready_q <= (st_q == dsl_pkg::DSL_IDLE) && !start && !pend_q && !load_outputs_n_go &&
                    (load_outputs_n_cnt_q == 4'h0);
      end
   end

   // 25 MHz at most with HALF_CYC of 1; 6.25 MHz as built
   assign link.sclk            = sclk_q;
   assign link.sync_n          = sync_q;
   assign link.serial_data_in  = sdi_q;
   assign link.load_outputs_n  = load_outputs_n_q;
   assign link.clear_outputs_n = clr_q;
   assign req_ready            = ready_q;
   assign rsp_valid            = rsp_v_q;
   assign rsp_word             = rsp_q;

endmodule : dsl_host

/* File: tb/dsl_link_chk.sv */
// concurrent checks on the wires between host end and converter end
`timescale 1ns/1ps
module dsl_link_chk
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic serial_data_in,
   input wire logic load_outputs_n,
   input wire logic sdo_oe,
   input wire logic sdo_line
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic [4:0] falls_q;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // falling sclk edges seen in the open frame; restarts at every frame start
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         falls_q <= 5'h00;
      else if ($fell(sync_n))
         falls_q <= 5'h00;
      else if (!sync_n && $fell(sclk))
         falls_q <= falls_q + 5'h01;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // frame close is the rising sync edge
   sequence frame_end;
      $rose(sync_n);
   endsequence

   a_frame_bits: assert property (frame_end |-> falls_q == dsl_pkg::CNT_FULL)
      else $error("frame closed without a full word");
   a_sync_gap: assert property (frame_end |-> sync_n [*5])
      else $error("sync high time too short");
   a_sclk_idle: assert property (sync_n |-> sclk)
      else $error("sclk moves outside a frame");
   a_sclk_rate: assert property ($changed(sclk) |=> $stable(sclk) [*3])
      else $error("sclk half period too short");
   a_sdi_setup: assert property ($fell(sclk) |-> $stable(serial_data_in))
      else $error("serial data moved at sampling edge");
   a_load_spacing: assert property ($fell(load_outputs_n) |->
      sync_n && $past(sync_n, 7))
      else $error("load fall too near a frame");
   // a driven output line may only move together with a rising sclk
   a_sdo_edge: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo_line) |->
      $rose(sclk))
      else $error("output line moved away from a rising sclk");
   a_sdo_enable: assert property ($rose(sdo_oe) |-> sync_n && $past(sync_n, 3))
      else $error("output enable changed inside a frame");
endmodule : dsl_link_chk

/* File: tb/dual_dac_serial_load_control_bench.sv */
// self-checking bench: host end and converter end joined on one link
`timescale 1ns/1ps
module dual_dac_serial_load_control_bench;
   localparam int LIMIT = 8000;   // about thirty-six frames of some 220 cycles each
   logic                             clk = 1'b0;
   logic                             rst_n;
   logic                             req_valid = 1'b0;
   logic [dsl_pkg::FRAME_BITS-1:0]   req_word = 24'h000000;
   logic                             req_ready;
   logic                             rsp_valid;
   logic [dsl_pkg::FRAME_BITS-1:0]   rsp_word;
   logic                             hold_outputs = 1'b0;
   logic                             load_strobe = 1'b0;
   logic                             clear_req = 1'b0;
   logic                             strap = 1'b1;
   logic [dsl_pkg::DATA_W-1:0]       code_a;
   logic [dsl_pkg::DATA_W-1:0]       code_b;
   logic                             bip;
   int                               error_cnt = 0;
   int                               checks = 0;
   int                               cyc = 0;

   dsl_if dsl_if_i ();
   dsl_host dsl_host_i (.clk(clk), .rst_n(rst_n), .link(dsl_if_i), .req_valid(req_valid),
      .req_word(req_word), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_word(rsp_word),
      .hold_outputs(hold_outputs), .load_strobe(load_strobe), .clear_req(clear_req));
   dsl_dev dsl_dev_i (.clk(clk), .rst_n(rst_n), .link(dsl_if_i), .bipolar_coding_select(strap),
      .dac_code_a(code_a), .dac_code_b(code_b), .bipolar_range(bip));
   dsl_link_chk dsl_link_chk_i (.clk(clk), .rst_n(rst_n), .sclk(dsl_if_i.sclk),
      .sync_n(dsl_if_i.sync_n), .serial_data_in(dsl_if_i.serial_data_in),
      .load_outputs_n(dsl_if_i.load_outputs_n), .sdo_oe(dsl_if_i.sdo_oe),
      .sdo_line(dsl_if_i.sdo_line));

   always #10 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // verdict and end of run, also reached from the hang guard
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   task automatic compare(input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : compare

   // one frame through the host port; returns once the answer pulse was seen
   task automatic xfer(input logic rd, input logic [2:0] sel, input logic [15:0] data);
      int n;
      n = 0;
      req_word <= {rd, 4'h0, sel, data};
      req_valid <= 1'b1;
      do @(posedge clk); while (req_ready !== 1'b1 && n++ < 400);
      req_valid <= 1'b0;
      do @(posedge clk); while (rsp_valid !== 1'b1 && n++ < 800);
      if (n >= 800)
         error_cnt++;
   endtask : xfer

   // clear held for a while; both outputs must sit at the clear code
   task automatic clr(input logic [15:0] exp);
      clear_req <= 1'b1;
      repeat (10) @(posedge clk);
      compare(code_a, exp);
      compare(code_b, exp);
      clear_req <= 1'b0;
      repeat (10) @(posedge clk);
   endtask : clr

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // hang guard: counts as a mismatch
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == LIMIT)
      begin
         error_cnt++;
         complete_run();
      end
   end

   initial
   begin
      // a real falling reset edge: the sclk-domain flops never see a falling sclk here
      rst_n <= 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      xfer(1'b0, dsl_pkg::REG_CHAN_A, 16'h1234);
      xfer(1'b0, dsl_pkg::REG_CHAN_B, 16'hBEEF);
      compare(code_a, 24'h001234);
      compare(code_b, 24'h00BEEF);
      clr(dsl_pkg::CODE_ZERO);
      hold_outputs <= 1'b1;
      xfer(1'b0, dsl_pkg::REG_CHAN_BOTH, 16'h5555);
      xfer(1'b0, dsl_pkg::REG_CHAN_B, 16'hAAAA);
      compare(code_a, dsl_pkg::CODE_ZERO);
      compare(code_b, dsl_pkg::CODE_ZERO);
      load_strobe <= 1'b1;
      @(posedge clk);
      load_strobe <= 1'b0;
      repeat (10) @(posedge clk);
      compare(code_a, 24'h005555);
      compare(code_b, 24'h00AAAA);
      // load pin falls at once; keep it clear of the next frame start
      hold_outputs <= 1'b0;
      repeat (10) @(posedge clk);
      // midscale clear, bipolar range, output line on
      xfer(1'b0, dsl_pkg::REG_CTRL, 16'h0007);
      compare(bip, 1'b1);
      xfer(1'b0, dsl_pkg::REG_CHAN_A, 16'h1234);
      compare(code_a, 24'h001234);
      strap <= 1'b0;
      xfer(1'b0, dsl_pkg::REG_CHAN_A, 16'h1234);
      compare(code_a, 16'h1234 ^ dsl_pkg::MSB_FLIP);
      xfer(1'b0, dsl_pkg::REG_CHAN_A, 16'h0000);
      compare(code_a, dsl_pkg::CODE_MID);
      clr(dsl_pkg::CODE_MID);
      // the read frame loads the word, the next one shifts it out
      xfer(1'b1, dsl_pkg::REG_CHAN_B, 16'h0000);
      xfer(1'b1, dsl_pkg::REG_CHAN_B, 16'h0000);
      compare(rsp_word[15:0], 24'h00AAAA);
      xfer(1'b0, dsl_pkg::REG_CTRL, 16'h0000);
      xfer(1'b0, dsl_pkg::REG_CHAN_A, 16'h1234);
      compare(code_a, 24'h001234);
      compare(rsp_word, 24'hFFFFFF);
      complete_run();
   end
endmodule : dual_dac_serial_load_control_bench
